// >>> common/pps_consts.svh
/*
 * Offsets, field positions, reset values and limits of the port
 * performance statistics selection block.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PPS_ADDR_W        12
`define PPS_OFF_CTRL      12'h000
`define PPS_OFF_CTR4      12'h004
`define PPS_OFF_CTR5      12'h008
`define PPS_OFF_STAT      12'h00C

// ----------------------------------------------------------------
// control word field positions
// ----------------------------------------------------------------
`define PPS_C4_PRI_LSB    0
`define PPS_C4_DIR_BIT    7
`define PPS_C4_CLS_LSB    13
`define PPS_C5_PRI_LSB    16
`define PPS_C5_DIR_BIT    23
`define PPS_C5_CLS_LSB    29

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define PPS_CTRL_RST      32'h0000_0000
`define PPS_CTRL_WMASK    32'hE08F_E08F
`define PPS_CTR_RST       32'h0000_0000
`define PPS_CTR_MAX       32'hFFFF_FFFF

`endif

// >>> common/pps_pkg.sv
/*
 * Types shared by the statistics selection block and its bench.
 * Assumes pps_consts.svh is available on the include path.
 */
`default_nettype none

package pps_pkg;

	// traffic classes, in the order of their 3-bit encodings 000..111
	typedef enum logic [2:0] {
		PPS_CLS_UC_REQ,
		PPS_CLS_UC_ALL,
		PPS_CLS_CS_RETRY,
		PPS_CLS_CS_OTHER,
		PPS_CLS_UC_WORDS,
		PPS_CLS_MC_PKT,
		PPS_CLS_MC_CS,
		PPS_CLS_MC_WORDS
	} pps_class_t;

	typedef enum logic [1:0] {
		PPS_FT_REQ,
		PPS_FT_RESP,
		PPS_FT_MAINT,
		PPS_FT_OTHER
	} pps_ftype_t;

	// one observed event per cycle and direction
	typedef struct packed {
		logic       pkt;       // packet accepted this cycle
		logic       cs;        // control symbol this cycle
		logic       cs_retry;  // control symbol is a retry
		logic       mcast;     // multicast packet or symbol
		pps_ftype_t ftype;     // packet type
		logic       hop_zero;  // maintenance hop count is zero
		logic       retried;   // packet was retried
		logic [1:0] prio;      // packet priority
		logic [6:0] words;     // packet length in 32-bit words
	} pps_evt_t;

	// per-counter selection
	typedef struct packed {
		pps_class_t cls;
		logic       dir;       // 0 receive, 1 transmit
		logic [3:0] pri_en;    // bit 0 prio 3 .. bit 3 prio 0
	} pps_cfg_t;

endpackage

`default_nettype wire

// >>> hdl/pps_evt_qual.sv
/*
 * Qualifies one cycle of observed traffic against one counter's
 * selection and produces a registered increment amount.
 * Assumes events come from logic on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module pps_evt_qual
	import pps_pkg::*;
(
	input  wire logic       ref_clk,  // clock
	input  wire logic       rst_n,    // async reset, active low
	input  wire pps_cfg_t   cfg,      // counter selection
	input  wire pps_evt_t   rx_evt,   // receive-side event
	input  wire pps_evt_t   tx_evt,   // transmit-side event
	output logic      [6:0] inc       // amount to add next edge
);

	function automatic logic [6:0] qual(input pps_cfg_t c, input pps_evt_t e);
		logic any_pri;
		logic pri_ok;
		logic uc_ok;
		logic mc_ok;
		any_pri = |c.pri_en;
		pri_ok  = c.pri_en[2'd3 - e.prio];
		uc_ok   = e.pkt && !e.mcast && !e.retried && pri_ok;           // RULE2 RULE19
		mc_ok   = e.pkt && e.mcast && !e.retried && pri_ok;            // RULE2 RULE19
		qual    = 7'h00;
		if (any_pri) begin                                             // RULE17 RULE13
			case (c.cls)
				PPS_CLS_UC_REQ:   qual = {6'h00, uc_ok && e.ftype == PPS_FT_REQ}; // RULE3
				PPS_CLS_UC_ALL:   qual = {6'h00, uc_ok};                           // RULE4
				PPS_CLS_CS_RETRY: qual = {6'h00, e.cs && e.cs_retry};              // RULE5 RULE11
				PPS_CLS_CS_OTHER: qual = {6'h00, e.cs && !e.cs_retry};             // RULE6 RULE11
				PPS_CLS_UC_WORDS: qual = uc_ok ? e.words : 7'h00;                  // RULE7
				PPS_CLS_MC_PKT:   qual = {6'h00, mc_ok};                           // RULE8
				PPS_CLS_MC_CS:    qual = {6'h00, e.cs && e.mcast};                 // RULE9 RULE11
				PPS_CLS_MC_WORDS: qual = mc_ok ? e.words : 7'h00;                  // RULE10
				default:          qual = 7'h00;
			endcase
		end
	endfunction

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inc <= 7'h00;
		end else begin
			inc <= qual(cfg, cfg.dir ? tx_evt : rx_evt); // RULE18 RULE14
		end
	end

endmodule // pps_evt_qual

`default_nettype wire

// >>> hdl/pps_sat_ctr.sv
/*
 * 32-bit saturating statistics counter with test write and clear.
 * Assumes write and clear are single-cycle strobes on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pps_consts.svh"

module pps_sat_ctr (
	input  wire logic        ref_clk,    // clock
	input  wire logic        rst_n,      // async reset, active low
	input  wire logic  [6:0] inc,        // amount to add
	input  wire logic        wr,         // test write strobe
	input  wire logic [31:0] wr_data,    // test write value
	input  wire logic        clr,        // clear strobe (read)
	output logic      [31:0] count,      // current value
	output logic      [31:0] next_count, // value after an edge with no write or clear
	output logic             sat         // counter is at maximum
);

	logic [32:0] sum;

	always_comb begin
		sum = {1'b0, count} + {26'h0, inc};
		next_count = sum[32] ? `PPS_CTR_MAX : sum[31:0];
	end

	// increment arriving with a clear is kept
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= `PPS_CTR_RST;
		end else if (wr) begin
			count <= wr_data;
		end else if (clr) begin
			count <= {25'h0, inc};
		end else begin
			count <= next_count;
		end
	end

	assign sat = (count == `PPS_CTR_MAX);

endmodule // pps_sat_ctr

`default_nettype wire

// >>> hdl/pps_stat_sel.sv
/*
 * Performance statistics selection for counters four and five: an APB
 * slave holding the control word, two qualifiers and two counters.
 * Assumes traffic events arrive synchronous to ref_clk and APB is
 * driven on ref_clk.
 */
// The implementer's own choices: the APB slave port and the register offsets.
// Overview of operation
// RULE1 - counter four class selector is bits 13..15, read/write, reset zero
// RULE2 - retried packets are never counted by either counter
// RULE3 - class 000 counts unicast requests only, no responses or maintenance
// RULE4 - class 001 counts every unicast packet, maintenance included
// RULE5 - class 010 counts retry control symbols only
// RULE6 - class 011 counts all control symbols except retry symbols
// RULE7 - class 100 adds one per 32-bit word of accepted unicast packets
// RULE8 - class 101 counts each multicast packet
// RULE9 - class 110 counts each multicast control symbol
// RULE10 - class 111 adds one per 32-bit word of multicast packets
// RULE11 - control symbols count whenever any priority bit is set
// RULE12 - counter five priority enables at bits 16..19, prio 3..0
// RULE13 - counter five disabled when its priority bits are all zero
// RULE14 - bit 23 picks receive (0) or transmit (1) for counter five
// RULE15 - counter five class selector is bits 29..31, same encodings
// RULE16 - counter four priority enables at bits 0..3, prio 3..0
// RULE17 - counter four disabled when its priority bits are all zero
// RULE18 - bit 7 picks receive (0) or transmit (1) for counter four
// RULE19 - a packet counts only if priority, direction and class all match
// RULE20 - reserved control bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "pps_consts.svh"

module pps_stat_sel
	import pps_pkg::*;
(
	input  wire logic                 ref_clk,  // 50 MHz clock
	input  wire logic                 rst_n,    // async reset, active low
	input  wire logic [`PPS_ADDR_W-1:0] paddr,  // APB address
	input  wire logic                 psel,     // APB select
	input  wire logic                 penable,  // APB enable
	input  wire logic                 pwrite,   // APB direction
	input  wire logic          [31:0] pwdata,   // APB write data
	input  wire logic           [3:0] pstrb,    // APB byte strobes
	output logic               [31:0] prdata,   // APB read data
	output logic                      pready,   // APB ready
	output logic                      pslverr,  // APB error
	input  wire pps_evt_t             rx_evt,   // receive traffic
	input  wire pps_evt_t             tx_evt    // transmit traffic
);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	function automatic logic mapped(input logic [`PPS_ADDR_W-1:0] a);
		mapped = (a == `PPS_OFF_CTRL) || (a == `PPS_OFF_CTR4) ||
		         (a == `PPS_OFF_CTR5) || (a == `PPS_OFF_STAT);
	endfunction

	function automatic logic [31:0] strb_merge(input logic [31:0] old,
	                                           input logic [31:0] wd,
	                                           input logic [3:0]  st);
		integer i;
		strb_merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (st[i]) begin
				strb_merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction

	logic setup;
	logic access;
	logic wr_ctrl;
	logic wr_ctr4;
	logic wr_ctr5;
	logic rd_ctr4;
	logic rd_ctr5;

	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign pready  = 1'b1;
	assign wr_ctrl = access && pwrite && paddr == `PPS_OFF_CTRL;
	assign wr_ctr4 = access && pwrite && paddr == `PPS_OFF_CTR4;
	assign wr_ctr5 = access && pwrite && paddr == `PPS_OFF_CTR5;
	assign rd_ctr4 = access && !pwrite && paddr == `PPS_OFF_CTR4;
	assign rd_ctr5 = access && !pwrite && paddr == `PPS_OFF_CTR5;

	// ------------------------------------------------------------
	// control word
	// ------------------------------------------------------------
	logic [31:0] ctrl;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `PPS_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= strb_merge(ctrl, pwdata, pstrb) & `PPS_CTRL_WMASK; // RULE20
		end
	end

	pps_cfg_t cfg4;
	pps_cfg_t cfg5;

	always_comb begin
		cfg4.pri_en = ctrl[`PPS_C4_PRI_LSB +: 4];                    // RULE16
		cfg4.dir    = ctrl[`PPS_C4_DIR_BIT];                         // RULE18
		cfg4.cls    = pps_class_t'(ctrl[`PPS_C4_CLS_LSB +: 3]);      // RULE1
		cfg5.pri_en = ctrl[`PPS_C5_PRI_LSB +: 4];                    // RULE12
		cfg5.dir    = ctrl[`PPS_C5_DIR_BIT];                         // RULE14
		cfg5.cls    = pps_class_t'(ctrl[`PPS_C5_CLS_LSB +: 3]);      // RULE15
	end

	// ------------------------------------------------------------
	// qualifiers and counters
	// ------------------------------------------------------------
	logic  [6:0] inc4;
	logic  [6:0] inc5;
	logic [31:0] cnt4;
	logic [31:0] cnt5;
	logic [31:0] nxt4;
	logic [31:0] nxt5;
	logic        sat4;
	logic        sat5;

	pps_evt_qual u_qual4 (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.cfg     (cfg4),
		.rx_evt  (rx_evt),
		.tx_evt  (tx_evt),
		.inc     (inc4)
	);

	pps_evt_qual u_qual5 (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.cfg     (cfg5),
		.rx_evt  (rx_evt),
		.tx_evt  (tx_evt),
		.inc     (inc5)
	);

	pps_sat_ctr u_ctr4 (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.inc        (inc4),
		.wr         (wr_ctr4),
		.wr_data    (strb_merge(cnt4, pwdata, pstrb)),
		.clr        (rd_ctr4),
		.count      (cnt4),
		.next_count (nxt4),
		.sat        (sat4)
	);

	pps_sat_ctr u_ctr5 (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.inc        (inc5),
		.wr         (wr_ctr5),
		.wr_data    (strb_merge(cnt5, pwdata, pstrb)),
		.clr        (rd_ctr5),
		.count      (cnt5),
		.next_count (nxt5),
		.sat        (sat5)
	);

	// ------------------------------------------------------------
	// read data and error
	// ------------------------------------------------------------
	// captured at setup so the access edge clear loses nothing
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= !mapped(paddr);
			case (paddr)
				`PPS_OFF_CTRL: prdata <= ctrl;
				`PPS_OFF_CTR4: prdata <= nxt4;
				`PPS_OFF_CTR5: prdata <= nxt5;
				`PPS_OFF_STAT: prdata <= {28'h0, sat5, sat4,
				                          |cfg5.pri_en, |cfg4.pri_en};
				default:       prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule // pps_stat_sel

`default_nettype wire

// >>> verification/pps_stat_sel_chk.sv
/* Port checker for pps_stat_sel, bound to every instance.
   Assumes APB writes carry all byte strobes. */
`timescale 1ns/1ps
`default_nettype none
`include "pps_consts.svh"
module pps_stat_sel_chk (
	input wire logic                   ref_clk, // clock
	input wire logic                   rst_n,   // async reset
	input wire logic [`PPS_ADDR_W-1:0] paddr,   // address
	input wire logic                   psel,    // select
	input wire logic                   penable, // enable
	input wire logic                   pwrite,  // direction
	input wire logic            [31:0] pwdata,  // write data
	input wire logic            [31:0] prdata,  // read data
	input wire logic                   pslverr  // error
);
	logic [31:0] sh;
	logic        live4;
	logic        live5;
	logic        en4_d;
	logic        en5_d;
	wire rs  = psel && !penable && !pwrite;
	wire acc = psel && penable;
	wire map = paddr inside {`PPS_OFF_CTRL, `PPS_OFF_CTR4, `PPS_OFF_CTR5, `PPS_OFF_STAT};
	wire cw    = acc && pwrite && paddr == `PPS_OFF_CTRL;
	wire en4_n = (|sh[3:0]) || (cw && (|pwdata[3:0]));
	wire en5_n = (|sh[19:16]) || (cw && (|pwdata[19:16]));
	wire clr4  = acc && !pwrite && paddr == `PPS_OFF_CTR4;
	wire clr5  = acc && !pwrite && paddr == `PPS_OFF_CTR5;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh <= '0;
		end else if (acc && pwrite && paddr == `PPS_OFF_CTRL) begin
			sh <= pwdata & `PPS_CTRL_WMASK;
		end
	end
	// set while a counter may hold a count since its last clearing read;
	// en_d covers the increment still in the qualifier pipeline
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			en4_d <= 1'b0;
			en5_d <= 1'b0;
			live4 <= 1'b0;
			live5 <= 1'b0;
		end else begin
			en4_d <= |sh[3:0];
			en5_d <= |sh[19:16];
			live4 <= en4_n || en4_d || (acc && pwrite && paddr == `PPS_OFF_CTR4) ||
			         (live4 && !clr4);
			live5 <= en5_n || en5_d || (acc && pwrite && paddr == `PPS_OFF_CTR5) ||
			         (live5 && !clr5);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_CTRL_RBACK: assert property (rs && paddr == `PPS_OFF_CTRL |=> prdata == sh)
		else $error("control word readback differs");
	AST_RSVD_ZERO: assert property (rs && paddr == `PPS_OFF_CTRL |=> (prdata & ~`PPS_CTRL_WMASK) == 0)
		else $error("reserved control bits not zero");
	AST_C4_EN: assert property (rs && paddr == `PPS_OFF_STAT |=> prdata[0] == |sh[3:0])
		else $error("counter four enable flag wrong");
	AST_C5_EN: assert property (rs && paddr == `PPS_OFF_STAT |=> prdata[1] == |sh[19:16])
		else $error("counter five enable flag wrong");
	AST_UNMAP_ERR: assert property (psel && !penable && !map |=> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	AST_MAP_OK: assert property (psel && !penable && map |=> !pslverr)
		else $error("mapped access flagged as error");
	AST_DIS4: assert property (rs && paddr == `PPS_OFF_CTR4 && !live4 |=> prdata == 0)
		else $error("disabled counter four moved");
	AST_DIS5: assert property (rs && paddr == `PPS_OFF_CTR5 && !live5 |=> prdata == 0)
		else $error("disabled counter five moved");
endmodule // pps_stat_sel_chk
bind pps_stat_sel pps_stat_sel_chk u_chk (.ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite,
	.pwdata, .prdata, .pslverr);
`default_nettype wire

// >>> verification/pps_link_model.sv
/* Link traffic model: replays one event per cycle on one side.
   Assumes send and its event change right after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module pps_link_model
	import pps_pkg::*;
(
	input  wire logic     ref_clk, // clock
	input  wire logic     rst_n,   // async reset
	input  wire logic     send,    // event valid
	input  wire logic     to_tx,   // 1 transmit side
	input  wire pps_evt_t ev,      // event to replay
	output var  pps_evt_t rx_evt,  // receive traffic
	output var  pps_evt_t tx_evt   // transmit traffic
);
	logic [14:0] junk;
	// idle cycles carry changing junk beside cleared pkt and cs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			junk <= '0;
			rx_evt <= '0;
			tx_evt <= '0;
		end else begin
			junk <= junk + 15'h1;
			rx_evt <= (send && !to_tx) ? ev : {2'b00, junk};
			tx_evt <= (send && to_tx) ? ev : {2'b00, ~junk};
		end
	end
endmodule // pps_link_model
`default_nettype wire

// >>> verification/pps_stat_sel_test.sv
/* Bench for pps_stat_sel: APB tasks and replayed traffic tables.
   Assumes the link model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "pps_consts.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module pps_stat_sel_test
	import pps_pkg::*;
;
	logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, snd = 0, sdir = 0, d;
	logic        pready, pslverr;
	logic [2:0]  c;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, e4, e5, w;
	pps_evt_t    sev = '0, rx_evt, tx_evt, tbl [12];
	int          num_errors = 0, n_compared = 0, cyc = 0;

	always #10 ref_clk = ~ref_clk;
	pps_stat_sel dut (.ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .rx_evt, .tx_evt);
	pps_link_model link (.ref_clk, .rst_n, .send(snd), .to_tx(sdir), .ev(sev), .rx_evt, .tx_evt);

	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	function automatic logic [31:0] ref_inc(logic [2:0] k, logic [3:0] pe, logic dr, logic ed,
		pps_evt_t e);
		logic u;
		logic m;
		u = e.pkt && pe[2'd3 - e.prio] && !e.mcast;
		m = e.pkt && pe[2'd3 - e.prio] && e.mcast;
		if (pe == 4'h0 || dr != ed || e.retried) return '0;
		case (k)
			3'h0: return {31'h0, u && e.ftype == PPS_FT_REQ};
			3'h1: return {31'h0, u};
			3'h2: return {31'h0, e.cs && e.cs_retry};
			3'h3: return {31'h0, e.cs && !e.cs_retry};
			3'h4: return u ? {25'h0, e.words} : '0;
			3'h5: return {31'h0, m};
			3'h6: return {31'h0, e.cs && e.mcast};
			default: return m ? {25'h0, e.words} : '0;
		endcase
	endfunction

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			end_sim();
		end
	end

	initial begin
		tbl = '{{4'h8, PPS_FT_REQ, 4'h0, 7'h05}, {4'h8, PPS_FT_RESP, 4'h1, 7'h03},
			{4'h8, PPS_FT_MAINT, 4'hA, 7'h04}, {4'h8, PPS_FT_REQ, 4'h4, 7'h06},
			{4'h9, PPS_FT_OTHER, 4'h3, 7'h09}, {4'h6, PPS_FT_REQ, 4'h0, 7'h00},
			{4'h4, PPS_FT_REQ, 4'h0, 7'h00}, {4'h5, PPS_FT_REQ, 4'h0, 7'h00},
			{4'h8, PPS_FT_REQ, 4'h3, 7'h02}, {4'h9, PPS_FT_OTHER, 4'h4, 7'h08},
			{4'h8, PPS_FT_REQ, 4'h1, 7'h01}, {4'h9, PPS_FT_REQ, 4'h0, 7'h04}};
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 16; a += 4) begin
			xfer(1'b0, a[11:0], 32'h0);
			`CHK("reset value", 32'h0, rd)
		end
		xfer(1'b1, `PPS_OFF_CTRL, 32'hFFFF_FFFF);
		xfer(1'b0, `PPS_OFF_CTRL, 32'h0);
		`CHK("write mask", `PPS_CTRL_WMASK, rd)
		xfer(1'b0, 12'h010, 32'h0);
		`CHK("unmapped read", 32'h0, rd)
		$display("test register access done");
		for (int i = 0; i < 16; i++) begin
			c = i[3:1];
			d = i[0];
			w = {~c, 5'h0, !d, 3'h0, d ? 4'h0 : 4'h7, c, 5'h0, d, 3'h0, d ? 4'hB : 4'h0};
			xfer(1'b1, `PPS_OFF_CTRL, w);
			xfer(1'b0, `PPS_OFF_CTRL, 32'h0);
			`CHK("control word", w, rd)
			xfer(1'b0, `PPS_OFF_CTR4, 32'h0);
			xfer(1'b0, `PPS_OFF_CTR5, 32'h0);
			e4 = '0;
			e5 = '0;
			for (int k = 0; k < 24; k++) begin
				@(posedge ref_clk);
				snd <= 1'b1;
				sdir <= (k >= 12);
				sev <= tbl[k % 12];
				e4 += ref_inc(c, w[3:0], d, k >= 12, tbl[k % 12]);
				e5 += ref_inc(~c, w[19:16], !d, k >= 12, tbl[k % 12]);
			end
			@(posedge ref_clk);
			snd <= 1'b0;
			repeat (2) @(posedge ref_clk);
			xfer(1'b0, `PPS_OFF_CTR4, 32'h0);
			`CHK("counter four", e4, rd)
			xfer(1'b0, `PPS_OFF_CTR5, 32'h0);
			`CHK("counter five", e5, rd)
			$display("test class %0d dir %0d done", c, d);
		end
		// counter four counts receive words, both counters test-written
		xfer(1'b1, `PPS_OFF_CTRL, 32'h0000_800F);
		xfer(1'b1, `PPS_OFF_CTR4, 32'hFFFF_FFF8);
		xfer(1'b1, `PPS_OFF_CTR5, 32'h0000_0123);
		xfer(1'b0, `PPS_OFF_STAT, 32'h0);
		`CHK("status before", 32'h1, rd)
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			snd <= 1'b1;
			sdir <= 1'b0;
			sev <= tbl[k];
		end
		@(posedge ref_clk);
		snd <= 1'b0;
		repeat (2) @(posedge ref_clk);
		xfer(1'b0, `PPS_OFF_STAT, 32'h0);
		`CHK("status saturated", 32'h5, rd)
		xfer(1'b0, `PPS_OFF_CTR4, 32'h0);
		`CHK("saturated count", 32'hFFFF_FFFF, rd)
		xfer(1'b0, `PPS_OFF_CTR4, 32'h0);
		`CHK("cleared count", 32'h0, rd)
		xfer(1'b0, `PPS_OFF_CTR5, 32'h0);
		`CHK("disabled test write", 32'h123, rd)
		$display("test saturation done");
		end_sim();
	end
endmodule // pps_stat_sel_test
`default_nettype wire
